// file: hdl/gpa_consts.vh
// Constants for the eight-bit general-purpose port with shared analog and oscillator pins
// Contract
// - Eight pins, each with direction, latch and pin-read bits at one position.
// - Direction one floats the pin; direction zero drives the latch value.
// - Pin-value read returns pin levels; a write there updates the latch.
// - Latch has its own address and reads back the latched value.
// - Pins six and seven follow oscillator mode; when not port, all bits read zero.
// - After reset pins five and three to zero are analog, pin four digital.
// - Analog control bits select analog use of pins three to zero and five.
// - Direction bit still controls the driver while a pin is analog.
// - Analog use disables digital input but leaves latch output untouched.
// - Reference output on pin two disables that pin's latch driver.
// - Pin two digital input is off under analog or reference output.
// - An enabled shared peripheral takes the pin away from general use; the code only blocks digital input on comparator input pins.
// - Comparator outputs on pins four and five override the latch data.
// - Pin six is a port pin only in freeing modes, clock out in clock-out modes, else neither.
// - Pin seven is no port pin in external oscillator modes.
`ifndef GPA_CONSTS_VH
`define GPA_CONSTS_VH

// Register byte offsets
`define GPA_OFS_PIN      8'h00
`define GPA_OFS_DIR      8'h04
`define GPA_OFS_LAT      8'h08
`define GPA_OFS_ANA      8'h0C
`define GPA_OFS_CMP      8'h10
`define GPA_OFS_OSC      8'h14

// Register selector codes
`define GPA_SEL_PIN      3'h0
`define GPA_SEL_DIR      3'h1
`define GPA_SEL_LAT      3'h2
`define GPA_SEL_ANA      3'h3
`define GPA_SEL_CMP      3'h4
`define GPA_SEL_OSC      3'h5
`define GPA_SEL_NONE     3'h7

// Reset values and writable masks
`define GPA_DIR_RST      8'hFF
`define GPA_LAT_RST      8'h00
`define GPA_ANA_RST      8'h2F
`define GPA_ANA_MASK     8'h2F
`define GPA_CMP_RST      8'h00
`define GPA_CMP_MASK     8'h0F
`define GPA_CMP_IN_PINS  8'h0F

// Comparator control fields
`define GPA_CMP_ON       0
`define GPA_CMP_ONE_OUT  1
`define GPA_CMP_TWO_OUT  2
`define GPA_CMP_REF_OUT  3

// Pin positions
`define GPA_PIN_REF      2
`define GPA_PIN_FOUR     4
`define GPA_PIN_FIVE     5
`define GPA_PIN_SIX      6
`define GPA_PIN_SEVEN    7

// Oscillator modes
`define GPA_OSC_XTAL     3'h0
`define GPA_OSC_EXT_CLKO 3'h1
`define GPA_OSC_EXT_IO   3'h2
`define GPA_OSC_INT_CLKO 3'h3
`define GPA_OSC_INT_IO   3'h4

// Bus encodings
`define GPA_HTRANS_NSEQ  2'h2
`define GPA_HSIZE_WORD   3'h2
`define GPA_HRESP_OKAY   1'h0

`endif

// file: hdl/gpa_port.v
// Eight-bit general-purpose port with AHB-Lite register access
`timescale 1ns/1ps
`include "gpa_consts.vh"
module gpa_port (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire [31:0] hrdata,
  output wire        hresp,
  // Port pins
  input  wire [7:0]  pinIn,
  output wire [7:0]  pinOut,
  output wire [7:0]  pinOeN,
  // Oscillator configuration strap
  input  wire [2:0]  cfgOscMode,
  // Shared peripherals
  input  wire        cmpOneResult,
  input  wire        cmpTwoResult,
  output wire        timerClkIn,
  output wire [7:0]  analogSelect,
  output wire        comparatorsOn,
  output wire        refOutEnable
);

  // Register selector shared by the write and read paths
  function [2:0] regSel;
    input [7:0] addr;
    begin
      case (addr)
        `GPA_OFS_PIN: regSel = `GPA_SEL_PIN;
        `GPA_OFS_DIR: regSel = `GPA_SEL_DIR;
        `GPA_OFS_LAT: regSel = `GPA_SEL_LAT;
        `GPA_OFS_ANA: regSel = `GPA_SEL_ANA;
        `GPA_OFS_CMP: regSel = `GPA_SEL_CMP;
        `GPA_OFS_OSC: regSel = `GPA_SEL_OSC;
        default:      regSel = `GPA_SEL_NONE;
      endcase
    end
  endfunction

  // Use of pins six and seven per oscillator mode: {clock out, six port, seven port}
  function [2:0] oscUse;
    input [2:0] mode;
    begin
      case (mode)
        `GPA_OSC_EXT_CLKO: oscUse = 3'h4;
        `GPA_OSC_EXT_IO:   oscUse = 3'h2;
        `GPA_OSC_INT_CLKO: oscUse = 3'h5;
        `GPA_OSC_INT_IO:   oscUse = 3'h3;
        default:           oscUse = 3'h0;
      endcase
    end
  endfunction

  // Port state
  reg  [7:0]  dir_reg;
  reg  [7:0]  dir_next;
  reg  [7:0]  lat_reg;
  reg  [7:0]  lat_next;
  reg  [7:0]  ana_reg;
  reg  [7:0]  ana_next;
  reg  [7:0]  cmp_reg;
  reg  [7:0]  cmp_next;
  reg  [2:0]  oscMode_reg;
  reg  [1:0]  clkDiv_reg;
  reg  [7:0]  pinOut_reg;
  reg  [7:0]  pinOeN_reg;

  // Bus state
  reg         wrPend_reg;
  reg         rdPend_reg;
  reg  [7:0]  addr_reg;
  reg  [31:0] hrdata_reg;
  reg  [7:0]  rdByte;

  // Per-pin decode
  wire [7:0]  syncPin;
  wire [7:0]  portEn;
  wire [7:0]  digInDis;
  wire [7:0]  pinRead;
  wire [7:0]  pinOutNext;
  wire [7:0]  pinOeNNext;
  wire        addrPhase;
  wire [2:0]  wrSel;
  wire [2:0]  rdSel;
  wire        pinSixClko;
  wire        pinSixPort;
  wire        pinSevenPort;
  wire [2:0]  oscUseBits;
  wire        cmpOn;
  wire        cmpOneOut;
  wire        cmpTwoOut;
  wire        refOut;

  // Strap synchroniser
  reg  [2:0]  oscMeta_reg;
  reg  [2:0]  oscSync_reg;

  gpa_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (pinIn),
    .syncOut  (syncPin)
  );

  // Strap is a pin, so it is resynchronised; reset must outlast these two stages
  // No reset here so the strap level is already settled when reset ends
  always @(posedge core_clk) begin
    oscMeta_reg <= cfgOscMode;
    oscSync_reg <= oscMeta_reg;
  end

  // Oscillator mode is caught while reset is held and stays fixed afterwards
  always @(posedge core_clk) begin
    if (sys_rst) begin
      oscMode_reg <= oscSync_reg;
    end
  end

  assign oscUseBits   = oscUse(oscMode_reg);
  assign pinSixClko   = oscUseBits[2];
  assign pinSixPort   = oscUseBits[1];
  assign pinSevenPort = oscUseBits[0];

  // Pins six and seven leave the port when the oscillator claims them
  assign portEn = {pinSevenPort, pinSixPort, 6'h3F};

  // Comparator control fields
  assign cmpOn     = cmp_reg[`GPA_CMP_ON];
  assign cmpOneOut = cmp_reg[`GPA_CMP_ONE_OUT];
  assign cmpTwoOut = cmp_reg[`GPA_CMP_TWO_OUT];
  assign refOut    = cmp_reg[`GPA_CMP_REF_OUT];

  // Digital input is blocked by analog select, comparator inputs and reference output
  assign digInDis = ana_reg |
                    ({8{cmpOn}} & `GPA_CMP_IN_PINS) |
                    {5'h00, refOut, 2'h0};

  assign pinRead = syncPin & portEn & ~digInDis;

  // Instruction-cycle clock is the core clock divided by four
  always @(posedge core_clk) begin
    if (sys_rst) begin
      clkDiv_reg <= 2'h0;
    end else begin
      clkDiv_reg <= clkDiv_reg + 2'h1;
    end
  end

  // Per-pin driver selection; each pin only looks at its own bits
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      if (i == `GPA_PIN_SIX) begin : g_six
        // Clock out drives whatever the direction bit says
        assign pinOutNext[i] = pinSixClko ? clkDiv_reg[1] :
                               (lat_reg[i] & pinSixPort);
        assign pinOeNNext[i] = pinSixClko ? 1'b0 :
                               (pinSixPort ? dir_reg[i] : 1'b1);
      end else if (i == `GPA_PIN_SEVEN) begin : g_seven
        assign pinOutNext[i] = lat_reg[i] & pinSevenPort;
        assign pinOeNNext[i] = pinSevenPort ? dir_reg[i] : 1'b1;
      end else if (i == `GPA_PIN_FOUR) begin : g_four
        assign pinOutNext[i] = cmpOneOut ?
                               cmpOneResult : lat_reg[i];
        assign pinOeNNext[i] = dir_reg[i];
      end else if (i == `GPA_PIN_FIVE) begin : g_five
        assign pinOutNext[i] = cmpTwoOut ?
                               cmpTwoResult : lat_reg[i];
        assign pinOeNNext[i] = dir_reg[i];
      end else if (i == `GPA_PIN_REF) begin : g_ref
        assign pinOutNext[i] = lat_reg[i];
        // Reference output wins so the analog level is not fought
        assign pinOeNNext[i] = refOut | dir_reg[i];
      end else begin : g_plain
        // Analog use leaves the driver alone; direction alone decides
        assign pinOutNext[i] = lat_reg[i];
        assign pinOeNNext[i] = dir_reg[i];
      end
    end
  endgenerate

  // Pins are registered so the pads never see decode glitches
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pinOut_reg <= 8'h00;
      pinOeN_reg <= 8'hFF;
    end else begin
      pinOut_reg <= pinOutNext;
      pinOeN_reg <= pinOeNNext;
    end
  end

  // Bus address phase
  assign addrPhase = hsel & (htrans == `GPA_HTRANS_NSEQ) & hready;
  assign wrSel = regSel(addr_reg);
  assign rdSel = regSel(addr_reg);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addr_reg   <= 8'h00;
    end else if (addrPhase) begin
      // Only whole-word writes change state
      wrPend_reg <= hwrite & (hsize == `GPA_HSIZE_WORD);
      rdPend_reg <= ~hwrite;
      addr_reg   <= haddr[7:0];
    end else begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
    end
  end

  // Register writes during the write data phase
  always @* begin
    dir_next = dir_reg;
    lat_next = lat_reg;
    ana_next = ana_reg;
    cmp_next = cmp_reg;
    if (wrPend_reg) begin
      case (wrSel)
        `GPA_SEL_PIN: begin
          lat_next = hwdata[7:0];
        end
        `GPA_SEL_DIR: begin
          dir_next = hwdata[7:0];
        end
        `GPA_SEL_LAT: begin
          lat_next = hwdata[7:0];
        end
        `GPA_SEL_ANA: begin
          ana_next = hwdata[7:0] & `GPA_ANA_MASK;
        end
        `GPA_SEL_CMP: begin
          cmp_next = hwdata[7:0] & `GPA_CMP_MASK;
        end
        default: begin
          dir_next = dir_reg;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      dir_reg <= `GPA_DIR_RST;
      lat_reg <= `GPA_LAT_RST;
      ana_reg <= `GPA_ANA_RST;
      cmp_reg <= `GPA_CMP_RST;
    end else begin
      dir_reg <= dir_next;
      lat_reg <= lat_next;
      ana_reg <= ana_next;
      cmp_reg <= cmp_next;
    end
  end

  // Read data; one wait state so a write just before is always seen
  always @* begin
    case (rdSel)
      `GPA_SEL_PIN: rdByte = pinRead;
      `GPA_SEL_DIR: rdByte = dir_reg & portEn;
      `GPA_SEL_LAT: rdByte = lat_reg & portEn;
      `GPA_SEL_ANA: rdByte = ana_reg;
      `GPA_SEL_CMP: rdByte = cmp_reg;
      `GPA_SEL_OSC: rdByte = {5'h00, oscMode_reg};
      default:      rdByte = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata_reg <= 32'h00000000;
    end else if (rdPend_reg) begin
      hrdata_reg <= {24'h000000, rdByte};
    end
  end

  assign hreadyout = ~rdPend_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = `GPA_HRESP_OKAY;

  // Pin and peripheral outputs
  assign pinOut        = pinOut_reg;
  assign pinOeN        = pinOeN_reg;
  assign timerClkIn    = syncPin[`GPA_PIN_FOUR];
  assign analogSelect  = ana_reg;
  assign comparatorsOn = cmpOn;
  assign refOutEnable  = refOut;

endmodule

// file: hdl/gpa_sync.v
// Two-flop synchroniser for the eight pin inputs
`timescale 1ns/1ps
module gpa_sync (
  // Clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Data
  input  wire [7:0] asyncIn,
  output wire [7:0] syncOut
);
  reg [7:0] stageOne_reg;
  reg [7:0] stageTwo_reg;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      stageOne_reg <= 8'h00;
      stageTwo_reg <= 8'h00;
    end else begin
      stageOne_reg <= asyncIn;
      stageTwo_reg <= stageOne_reg;
    end
  end

  assign syncOut = stageTwo_reg;
endmodule

// file: tb/gpa_pin_model.sv
// Board-side pin model: device drive, board drive or a floating line
`timescale 1ns/1ps
module gpa_pin_model (
  // Clock
  input  wire       core_clk,
  // Device side
  input  wire [7:0] pinOut,
  input  wire [7:0] pinOeN,
  // Board drive
  input  wire [7:0] extLevel,
  input  wire [7:0] extOn,
  output wire [7:0] pinIn
);
  reg [7:0] floatLvl_reg = 8'h00;
  // An unheld line wanders so a stale level never passes for a real one
  always @(posedge core_clk) floatLvl_reg <= ~floatLvl_reg;
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & extOn & extLevel)
    | (pinOeN & ~extOn & floatLvl_reg);
endmodule

// file: tb/gpa_port_props.sv
// Checker for bus timing and pin control of the eight-bit port
`timescale 1ns/1ps
`include "gpa_consts.vh"
module gpa_port_props (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  // Pins and peripherals
  input wire [7:0]  pinIn,
  input wire [7:0]  pinOeN,
  input wire        timerClkIn,
  input wire [7:0]  analogSelect,
  input wire        comparatorsOn,
  input wire        refOutEnable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire take = hsel && htrans == `GPA_HTRANS_NSEQ && hready;
  wire wordWr = take && hwrite && hsize == `GPA_HSIZE_WORD;
  reg  anaWr_reg;
  reg  cmpWr_reg;
  always @(posedge core_clk) begin
    anaWr_reg <= wordWr && haddr[7:0] == `GPA_OFS_ANA;
    cmpWr_reg <= wordWr && haddr[7:0] == `GPA_OFS_CMP;
  end
  sequence s_rdTake; take && !hwrite; endsequence
  sequence s_oneWait; !hreadyout ##1 hreadyout; endsequence
  property p_readWait; s_rdTake |=> s_oneWait; endproperty
  property p_writeNoWait; take && hwrite |=> hreadyout; endproperty
  property p_okay; hresp == `GPA_HRESP_OKAY; endproperty
  // Two-flop sync is two edges, five stable samples give margin
  property p_timerSync;
    (!sys_rst && $stable(pinIn[4]))[*5] |-> timerClkIn == pinIn[4];
  endproperty
  property p_refOff; refOutEnable[*2] |-> pinOeN[`GPA_PIN_REF]; endproperty
  property p_resetVals;
    $fell(sys_rst) |-> analogSelect == `GPA_ANA_RST && pinOeN == `GPA_DIR_RST
      && !comparatorsOn && !refOutEnable;
  endproperty
  property p_anaByWrite; $changed(analogSelect) |-> $past(anaWr_reg); endproperty
  property p_cmpByWrite;
    $changed({comparatorsOn, refOutEnable}) |-> $past(cmpWr_reg);
  endproperty
  a_readWait: assert property (p_readWait)
    else $error("read wait state wrong");
  a_writeNoWait: assert property (p_writeNoWait)
    else $error("write stalled");
  a_okay: assert property (p_okay)
    else $error("response not okay");
  a_timerSync: assert property (p_timerSync)
    else $error("timer clock input lost pin four level");
  a_refOff: assert property (p_refOff)
    else $error("pin two driven under reference output");
  a_resetVals: assert property (p_resetVals)
    else $error("reset configuration wrong");
  a_anaByWrite: assert property (p_anaByWrite)
    else $error("analog select changed without write");
  a_cmpByWrite: assert property (p_cmpByWrite)
    else $error("comparator control changed without write");
endmodule

bind gpa_port gpa_port_props gpa_port_props_inst (.core_clk, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp, .pinIn, .pinOeN, .timerClkIn,
  .analogSelect, .comparatorsOn, .refOutEnable);

// file: tb/tb_top.sv
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
`include "gpa_consts.vh"
module tb_top;
  reg         core_clk, sys_rst, hsel, hwrite, cmpOneResult, cmpTwoResult, rdPend_reg;
  reg  [31:0] haddr, hwdata, r;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize, cfgOscMode;
  reg  [7:0]  extLevel, extOn, v, d, x;
  reg  [47:0] modeDir;
  wire        hreadyout, hresp, timerClkIn, comparatorsOn, refOutEnable;
  wire [31:0] hrdata;
  wire [7:0]  pinIn, pinOut, pinOeN, analogSelect;
  integer     errors, total_checks, seed, cyc, i, m;
  reg  [31:0] expQ[$];

  gpa_port gpa_port_inst (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pinIn, .pinOut, .pinOeN,
    .cfgOscMode, .cmpOneResult, .cmpTwoResult, .timerClkIn, .analogSelect,
    .comparatorsOn, .refOutEnable);
  gpa_pin_model gpa_pin_model_inst (.core_clk, .pinOut, .pinOeN, .extLevel, .extOn, .pinIn);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task check(input string nm, input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task busW(input [7:0] a, input [7:0] dat, input [2:0] sz = `GPA_HSIZE_WORD);
    haddr <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= `GPA_HTRANS_NSEQ;
    hsize <= sz;
    hsel <= 1'b1;
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, dat};
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
  endtask

  // The monitor below compares the answer against this note
  task busR(input [7:0] a, input [31:0] exp);
    expQ.push_back(exp);
    haddr <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= `GPA_HTRANS_NSEQ;
    hsize <= `GPA_HSIZE_WORD;
    hsel <= 1'b1;
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
    htrans <= 2'h0;
    @(posedge core_clk);
    while (!hreadyout) @(posedge core_clk);
  endtask

  task rst(input [2:0] mode);
    sys_rst <= 1'b1;
    cfgOscMode <= mode;
    htrans <= 2'h0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    if (rdPend_reg && hreadyout) begin
      check("hrdata", hrdata, expQ.pop_front());
      rdPend_reg <= 1'b0;
    end
    if (!sys_rst && hsel && htrans == `GPA_HTRANS_NSEQ && hreadyout && !hwrite)
      rdPend_reg <= 1'b1;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      end_sim;
    end
  end

  initial begin
    seed = 58; errors = 0; total_checks = 0; cyc = 0; rdPend_reg = 1'b0;
    sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = `GPA_HSIZE_WORD; hwdata = 32'h0; cfgOscMode = `GPA_OSC_INT_IO;
    cmpOneResult = 1'b0; cmpTwoResult = 1'b0; extLevel = 8'hFF; extOn = 8'hFF;
    modeDir = 48'h3FFFBF7F3F3F;
    rst(`GPA_OSC_INT_IO);
    busR(`GPA_OFS_DIR, 8'hFF);
    busR(`GPA_OFS_ANA, 8'h2F);
    busR(`GPA_OFS_PIN, 8'hD0);
    busW(`GPA_OFS_ANA, 8'h00);
    busW(`GPA_OFS_CMP, 8'h00);
    busR(`GPA_OFS_PIN, 8'hFF);
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      v = r[7:0];
      d = r[15:8];
      x = r[23:16];
      // Board drives only the pins left as inputs
      extOn <= d;
      extLevel <= x;
      busW(`GPA_OFS_PIN, v);
      busW(`GPA_OFS_DIR, d);
      repeat (3) @(posedge core_clk);
      check("pinOeN", pinOeN, d);
      check("pinOut", pinOut & ~d, v & ~d);
      busR(`GPA_OFS_LAT, v);
      busR(`GPA_OFS_PIN, (v & ~d) | (x & d));
    end
    busW(`GPA_OFS_LAT, 8'h5A, 3'h0);
    busR(`GPA_OFS_LAT, v);
    busW(8'h1C, 8'hFF);
    busR(8'h1C, 8'h00);
    // Analog pins driven against advice, to show direction still rules
    busW(`GPA_OFS_ANA, 8'h2F);
    busW(`GPA_OFS_DIR, 8'h00);
    busW(`GPA_OFS_LAT, 8'hFF);
    busW(`GPA_OFS_CMP, 8'h08);
    extOn <= 8'h00;
    repeat (3) @(posedge core_clk);
    check("pinOeN", pinOeN, 8'h04);
    check("pinOut", pinOut & 8'hFB, 8'hFB);
    busR(`GPA_OFS_PIN, 8'hD0);
    cmpOneResult <= 1'b1;
    busW(`GPA_OFS_CMP, 8'h07);
    repeat (5) @(posedge core_clk);
    check("pinOut", pinOut[5:4], 2'h1);
    check("timerClkIn", timerClkIn, 1'b1);
    for (m = 0; m < 6; m = m + 1) begin
      rst(m[2:0]);
      busR(`GPA_OFS_OSC, m);
      busR(`GPA_OFS_DIR, modeDir[m*8 +: 8]);
      busW(`GPA_OFS_LAT, 8'hFF);
      busR(`GPA_OFS_LAT, modeDir[m*8 +: 8]);
      check("pinOeN6", pinOeN[6], !(m == 1 || m == 3));
      x[0] = pinOut[6];
      repeat (2) @(posedge core_clk);
      check("pinOut6", pinOut[6], (m == 1 || m == 3) ? !x[0] : (m == 2 || m == 4));
    end
    end_sim;
  end
endmodule
